/* core/sleep_wake_clock_switch_ctrl.sv */
// Purpose : sleep entry and wake, status flags, watchdog clear, clock source switching
// Assumes : sleep_req is a one-cycle strobe from the core decoding the sleep instruction
// Notes   : full resets (pin, brown-out, power-on) arrive on rst; watchdog and irq resume
`timescale 1ns/1ns
module sleep_wake_clock_switch_ctrl
  import sleep_ctrl_pkg::*;
#(
  parameter int unsigned WDT_W = 16,
  parameter int unsigned IO_W  = 5
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             sleep_req,
  input  wire logic             irq_pending,
  input  wire logic             irq_async,
  input  wire logic             wdt_en,
  input  wire logic             wdt_sleep_en,
  input  wire logic             wdt_clr,
  input  wire logic             global_interrupt_enable,
  input  wire logic [1:0]       config_osc_sel,
  input  wire logic             timer1_src_lf,
  input  wire logic             timer1_src_pin,
  input  wire logic             adc_src_rc,
  input  wire logic [IO_W-1:0]  io_out_in,
  input  wire logic [IO_W-1:0]  io_oe_in,
  input  wire logic [3:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [7:0]       reg_rdata,
  output logic                  cpu_clk_en,
  output logic                  lf_osc_en,
  output logic                  timer1_run,
  output logic                  adc_run,
  output logic      [IO_W-1:0]  io_out,
  output logic      [IO_W-1:0]  io_oe,
  output logic                  prefetch_req,
  output logic                  resume_pulse,
  output logic                  vector_isr,
  output logic                  watchdog_reset_req,
  output logic      [1:0]       clk_src_sel,
  output logic                  powerdown_flag,
  output logic                  timeout_flag_n
);

  //////////////////////////////////////////////////////////////////////////////
  // state and registers

  pwr_state_t        state_q;
  logic [1:0]        system_clock_select_q;
  logic [3:0]        internal_freq_select_q;
  logic              powerdown_flag_q;
  logic              timeout_flag_n_q;
  logic [WDT_W-1:0]  wdt_cnt_q;
  logic              wdt_wake_q;
  logic [IO_W-1:0]   io_out_q;
  logic [IO_W-1:0]   io_oe_q;
  logic [7:0]        rdata_q;
  logic [SETTLE_W-1:0] settle_q;
  logic              switching_q;
  logic [3:0]        ready_q;
  logic              pll_ready_flag_q;
  clk_src_t          active_src_q;
  logic              vector_q;
  wake_sync_if       wsync ();

  // derived conditions
  logic sleep_nop;
  logic sleep_enter;
  logic in_sleep;
  logic wake_now;
  logic osc_ctrl_wr;

  // decodes the select field into a clock source kind; used three times
  function automatic clk_src_t decode_src(input logic [1:0] sel, input logic [3:0] freq);
    if (sel == SEL_CONFIG) begin
      decode_src = SRC_EXTERNAL;
    end else if (sel == SEL_SECONDARY) begin
      decode_src = SRC_SECONDARY;
    end else if (freq == FREQ_LF) begin
      decode_src = SRC_LF_INTERNAL;
    end else begin
      decode_src = SRC_HF_INTERNAL;
    end
  endfunction

  // settle count for the chosen target
  function automatic logic [SETTLE_W-1:0] settle_of(input clk_src_t s);
    case (s)
      SRC_LF_INTERNAL: settle_of = SETTLE_W'(LF_SETTLE_CYC);
      SRC_HF_INTERNAL: settle_of = SETTLE_W'(HF_SETTLE_CYC);
      default:         settle_of = SETTLE_W'(EXT_SETTLE_CYC);
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // wake synchroniser

  // asynchronous wakes are resampled on the free-running clk, with the core clock still stopped, before fetch resumes
  wake_sync u_wake_sync (
    .clk     (clk),
    .rst     (rst),
    .irq_raw (irq_async),
    .wdt_raw (wdt_wake_q),
    .sync    (wsync.src)
  );

  //////////////////////////////////////////////////////////////////////////////
  // sleep sequencer

  assign in_sleep    = (state_q == PWR_SLEEP);
  // pending enabled interrupt turns the instruction into a no-op
  assign sleep_nop   = (state_q == PWR_RUN) && sleep_req && irq_pending;
  assign sleep_enter = (state_q == PWR_RUN) && sleep_req && !irq_pending;
  // interrupt wakes on its own enable, global enable ignored here
  assign wake_now    = wsync.irq_wake || wsync.wdt_wake;

  // the only entry path is the sleep strobe; late interrupts still complete entry
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= PWR_RUN;
    end else begin
      case (state_q)
        PWR_RUN: begin
          if (sleep_enter) begin
            state_q <= PWR_SLEEP;
          end
        end
        PWR_SLEEP: begin
          if (irq_async || wdt_wake_q) begin
            state_q <= PWR_WAKE_SYNC;
          end
        end
        PWR_WAKE_SYNC: begin
          if (wake_now) begin
            state_q <= PWR_RESUME;
          end
        end
        PWR_RESUME: state_q <= PWR_RUN;
        default:    state_q <= PWR_RUN;
      endcase
    end
  end

  // status flags: reset gives power-down 1, time-out 1; entry clears/sets them
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      powerdown_flag_q <= 1'b1;
      timeout_flag_n_q <= 1'b1;
    end else if (sleep_enter) begin
      powerdown_flag_q <= 1'b0;
      timeout_flag_n_q <= 1'b1;
    end else if (wdt_clr) begin
      powerdown_flag_q <= 1'b1;
      timeout_flag_n_q <= 1'b1;
    end else if (wdt_wake_q && !in_sleep) begin
      timeout_flag_n_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // watchdog

  // cleared on entry and on wake, never on a no-op sleep; counts in sleep only if enabled
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wdt_cnt_q  <= '0;
      wdt_wake_q <= 1'b0;
    end else if (sleep_enter || (state_q == PWR_RESUME) || wdt_clr) begin
      wdt_cnt_q  <= '0;
      wdt_wake_q <= 1'b0;
    end else if (wdt_en && (!in_sleep || wdt_sleep_en)) begin
      wdt_cnt_q  <= wdt_cnt_q + 1'b1;
      wdt_wake_q <= wdt_wake_q || (&wdt_cnt_q);
    end
  end

  // a watchdog overflow in run forces a reset; in sleep it only wakes
  assign watchdog_reset_req = wdt_wake_q && (state_q == PWR_RUN);

  //////////////////////////////////////////////////////////////////////////////
  // pins and peripheral enables

  // pin drive latched at entry and frozen for the whole sleep
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      io_out_q <= '0;
      io_oe_q  <= '0;
    end else if (state_q == PWR_RUN) begin
      io_out_q <= io_out_in;
      io_oe_q  <= io_oe_in;
    end
  end

  assign io_out       = io_out_q;
  assign io_oe        = io_oe_q;
  assign cpu_clk_en   = (state_q == PWR_RUN) || (state_q == PWR_RESUME);
  assign lf_osc_en    = 1'b1;
  assign timer1_run   = !in_sleep || timer1_src_lf || timer1_src_pin;
  assign adc_run      = !in_sleep || adc_src_rc;
  // prefetch of the next address is issued with the sleep instruction
  assign prefetch_req = sleep_enter || sleep_nop;
  assign resume_pulse = (state_q == PWR_RESUME);

  // vector only after the prefetched instruction, and only with global enable set
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      vector_q <= 1'b0;
    end else begin
      vector_q <= resume_pulse && global_interrupt_enable && !wdt_wake_q;
    end
  end
  assign vector_isr = vector_q;

  //////////////////////////////////////////////////////////////////////////////
  // clock switching

  assign osc_ctrl_wr = reg_wr && (reg_addr == ADDR_OSC_CTRL) && (state_q == PWR_RUN);

  // select field clears on every reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      system_clock_select_q  <= SEL_CONFIG;
      internal_freq_select_q <= FREQ_RESET;
    end else if (osc_ctrl_wr) begin
      system_clock_select_q  <= reg_wdata[1:0];
      internal_freq_select_q <= reg_wdata[7:4];
    end
  end

  // settle counter starts on every select write, source changes when it expires
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      settle_q     <= '0;
      switching_q  <= 1'b0;
      active_src_q <= SRC_EXTERNAL;
    end else if (osc_ctrl_wr) begin
      settle_q    <= settle_of(decode_src(reg_wdata[1:0], reg_wdata[7:4]));
      switching_q <= 1'b1;
    end else if (switching_q) begin
      if (settle_q <= SETTLE_W'(1)) begin
        switching_q  <= 1'b0;
        active_src_q <= decode_src(system_clock_select_q, internal_freq_select_q);
      end else begin
        settle_q <= settle_q - SETTLE_W'(1);
      end
    end
  end

  // one ready bit per source, pll flag tracks the pll-derived selection
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ready_q          <= 4'h1;
      pll_ready_flag_q <= 1'b0;
    end else if (switching_q && (settle_q <= SETTLE_W'(1))) begin
      ready_q          <= 4'h1 << decode_src(system_clock_select_q, internal_freq_select_q);
      pll_ready_flag_q <= system_clock_select_q[1]
                          && (internal_freq_select_q == FREQ_PLL);
    end
  end

  assign clk_src_sel    = active_src_q;
  assign powerdown_flag = powerdown_flag_q;
  assign timeout_flag_n = timeout_flag_n_q;

  //////////////////////////////////////////////////////////////////////////////
  // register read port

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_OSC_CTRL:  rdata_q <= {internal_freq_select_q, 2'h0, system_clock_select_q};
        ADDR_OSC_STAT:  rdata_q <= {switching_q, 2'h0, pll_ready_flag_q, ready_q};
        ADDR_CORE_STAT: rdata_q <= {5'h00, state_q == PWR_SLEEP,
                                    timeout_flag_n_q, powerdown_flag_q};
        ADDR_WAKE_CFG:  rdata_q <= WAKE_CFG_RESET;
        ADDR_WDT_CNT:   rdata_q <= 8'(wdt_cnt_q);
        default:        rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end
  assign reg_rdata = rdata_q;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_enter;
    sleep_req && !irq_pending && (state_q == PWR_RUN);
  endsequence

  chk_entry_flags: assert property (@(posedge clk) disable iff (rst)
    s_enter |=> !powerdown_flag_q && timeout_flag_n_q)
    else $error("entry did not update status flags");

  chk_nop_flags: assert property (@(posedge clk) disable iff (rst)
    sleep_nop |=> $stable(powerdown_flag_q) && state_q == PWR_RUN)
    else $error("no-op sleep changed state or flags");

  chk_wdt_entry_clear: assert property (@(posedge clk) disable iff (rst)
    s_enter |=> wdt_cnt_q == '0)
    else $error("watchdog not cleared on entry");

  chk_clk_gated: assert property (@(posedge clk) disable iff (rst)
    in_sleep |-> !cpu_clk_en && lf_osc_en)
    else $error("core clock running in sleep");

  chk_pins_hold: assert property (@(posedge clk) disable iff (rst)
    in_sleep && $past(in_sleep) |-> $stable(io_out) && $stable(io_oe))
    else $error("pins moved during sleep");

  chk_wake_resume: assert property (@(posedge clk) disable iff (rst)
    state_q == PWR_RESUME |=> wdt_cnt_q == '0 && state_q == PWR_RUN)
    else $error("wake did not clear watchdog");

  chk_sleep_only_cmd: assert property (@(posedge clk) disable iff (rst)
    $rose(in_sleep) |-> $past(sleep_req) && !$past(irq_pending))
    else $error("sleep entered without instruction");

  // helper for the settle check: counts the cycles of the switch in progress,
  // so the check needs no long repetition; a new write restarts the count
  logic [SETTLE_W-1:0] chk_settle_cnt_q;
  logic                chk_hf_target_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chk_settle_cnt_q <= '0;
      chk_hf_target_q  <= 1'b0;
    end else if (osc_ctrl_wr) begin
      chk_settle_cnt_q <= '0;
      chk_hf_target_q  <= reg_wdata[1] && (reg_wdata[7:4] != FREQ_LF);
    end else if (switching_q) begin
      chk_settle_cnt_q <= chk_settle_cnt_q + SETTLE_W'(1);
    end
  end

  chk_hf_settle: assert property (@(posedge clk) disable iff (rst)
    $fell(switching_q) && chk_hf_target_q |-> chk_settle_cnt_q == SETTLE_W'(HF_SETTLE_CYC))
    else $error("high-frequency settle time wrong");

endmodule

/* core/sleep_ctrl_pkg.sv */
// Purpose : shared constants and types for the sleep, wake and clock switch controller
// Assumes : single 10 MHz system clock, synchronous inputs except irq_async
// Notes   : register offsets are word indices on the plain register port
package sleep_ctrl_pkg;

  localparam int unsigned CLK_HZ           = 10_000_000;
  localparam int unsigned HF_SETTLE_NS     = 2_000;
  localparam int unsigned HF_SETTLE_CYC    = (HF_SETTLE_NS * (CLK_HZ / 1_000_000)) / 1_000;
  localparam int unsigned LF_SETTLE_CYC    = 1;
  localparam int unsigned EXT_SETTLE_CYC   = 2;
  localparam int unsigned SETTLE_W         = 8;

  localparam logic [3:0] ADDR_OSC_CTRL     = 4'h0;
  localparam logic [3:0] ADDR_OSC_STAT     = 4'h1;
  localparam logic [3:0] ADDR_CORE_STAT    = 4'h2;
  localparam logic [3:0] ADDR_WAKE_CFG     = 4'h3;
  localparam logic [3:0] ADDR_WDT_CNT      = 4'h4;

  localparam logic [1:0] SEL_CONFIG        = 2'h0;
  localparam logic [1:0] SEL_SECONDARY     = 2'h1;
  localparam logic [3:0] FREQ_LF           = 4'h0;
  localparam logic [3:0] FREQ_PLL          = 4'hF;
  localparam logic [3:0] FREQ_RESET        = 4'h7;

  localparam logic [7:0] WAKE_CFG_RESET    = 8'h00;

  typedef enum logic [1:0] {
    SRC_EXTERNAL,
    SRC_SECONDARY,
    SRC_LF_INTERNAL,
    SRC_HF_INTERNAL
  } clk_src_t;

  typedef enum {
    PWR_RUN,
    PWR_SLEEP,
    PWR_WAKE_SYNC,
    PWR_RESUME
  } pwr_state_t;

endpackage

/* core/wake_sync_if.sv */
// Purpose : carries synchronised wake requests between the synchroniser and the controller
// Assumes : one clock domain
// Notes   : none
`timescale 1ns/1ns
interface wake_sync_if;
  logic irq_wake;
  logic wdt_wake;
  modport src (output irq_wake, output wdt_wake);
  modport dst (input irq_wake, input wdt_wake);
endinterface

/* core/wake_sync.sv */
// Purpose : two-stage synchroniser for wake events arriving while the core clock is stopped
// Assumes : events may change at any time relative to clk
// Notes   : first stage is read only by the second stage
`timescale 1ns/1ns
module wake_sync (
  input  wire logic  clk,
  input  wire logic  rst,
  input  wire logic  irq_raw,
  input  wire logic  wdt_raw,
  wake_sync_if.src   sync
);
  logic [1:0] meta_q;
  logic [1:0] stable_q;

  // two flops per event, first stage feeds only the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q   <= 2'h0;
      stable_q <= 2'h0;
    end else begin
      meta_q   <= {wdt_raw, irq_raw};
      stable_q <= meta_q;
    end
  end

  assign sync.irq_wake = stable_q[0];
  assign sync.wdt_wake = stable_q[1];
endmodule

/* dv/wake_source_model.sv */
// Purpose : stand-in for the interrupt sources that wake a sleeping core
// Assumes : one clock; the controller sees the wake request as a level
// Notes   : request rises a set number of cycles into sleep, drops when the core runs
`timescale 1ns/1ns
module wake_source_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       arm,
  input  wire logic [7:0] delay,
  input  wire logic       cpu_clk_en,
  output logic            irq_async
);
  logic [7:0] wait_q;
  ////////////////////////////////////////////////////////////////////////////////
  // count stopped-clock cycles; a zero delay models a late, immediate interrupt
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_q    <= 8'h00;
      irq_async <= 1'b0;
    end else if (cpu_clk_en || !arm) begin
      wait_q    <= 8'h00;
      irq_async <= 1'b0;
    end else if (wait_q == delay) begin
      irq_async <= 1'b1;
    end else begin
      wait_q <= wait_q + 8'h01;
    end
  end
endmodule

/* dv/sleep_wake_clock_switch_ctrl_tb.sv */
// Purpose : self-checking bench for sleep entry, wake and clock switching
// Assumes : watchdog off except in its own overflow case near the end
// Notes   : clock switch cases are table rows; sleep cases are hand-written
`timescale 1ns/1ns
module sleep_wake_clock_switch_ctrl_tb;
  import sleep_ctrl_pkg::*;
  typedef struct {logic [7:0] wdata; logic [1:0] src; logic pll; logic slow;} sw_row_t;
  logic       clk, rst, sleep_req, irq_pending, irq_async, irq_glb_en, arm;
  logic       wdt_en, t1_lf, t1_pin, adc_rc;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, delay, rd;
  logic       reg_wr, reg_rd, cpu_clk_en, lf_osc_en, timer1_run, adc_run, prefetch_req;
  logic       resume_pulse, vector_isr, wd_req, powerdown_flag, timeout_flag_n;
  logic [4:0] io_out_in, io_oe_in, io_out, io_oe, io_exp;
  logic [1:0] clk_src_sel;
  int         fails, checks, n;
  // last row leaves a non-zero select so the mid-sleep reset has work to do
  sw_row_t    rows [4] = '{'{8'hF2, 2'h3, 1'b1, 1'b1}, '{8'h03, 2'h2, 1'b0, 1'b0},
                           '{8'h00, 2'h0, 1'b0, 1'b0}, '{8'h01, 2'h1, 1'b0, 1'b0}};
  ////////////////////////////////////////////////////////////////////////////////
  sleep_wake_clock_switch_ctrl #(.WDT_W(4), .IO_W(5)) sleep_wake_clock_switch_ctrl_i (
    .clk(clk), .rst(rst), .sleep_req(sleep_req), .irq_pending(irq_pending),
    .irq_async(irq_async), .wdt_en(wdt_en), .wdt_sleep_en(1'b0), .wdt_clr(1'b0),
    .global_interrupt_enable(irq_glb_en), .config_osc_sel(2'h0), .timer1_src_lf(t1_lf),
    .timer1_src_pin(t1_pin), .adc_src_rc(adc_rc), .io_out_in(io_out_in), .io_oe_in(io_oe_in),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cpu_clk_en(cpu_clk_en), .lf_osc_en(lf_osc_en),
    .timer1_run(timer1_run), .adc_run(adc_run), .io_out(io_out), .io_oe(io_oe),
    .prefetch_req(prefetch_req), .resume_pulse(resume_pulse), .vector_isr(vector_isr),
    .watchdog_reset_req(wd_req), .clk_src_sel(clk_src_sel),
    .powerdown_flag(powerdown_flag), .timeout_flag_n(timeout_flag_n));
  wake_source_model wake_source_model_i (
    .clk(clk), .rst(rst), .arm(arm), .delay(delay), .cpu_clk_en(cpu_clk_en),
    .irq_async(irq_async));
  ////////////////////////////////////////////////////////////////////////////////
  // comparisons, one per result width
  task automatic cmp1(input string what, input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %b exp %b", $time, what, got, exp);
    end
  endtask
  task automatic cmp8(input string what, input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // register port: one-cycle strobes, read data stands in the following cycle
  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic check_reset_state();
    logic [7:0] v;
    cmp1("powerdown after reset", powerdown_flag, 1'b1);
    cmp1("timeout after reset", timeout_flag_n, 1'b1);
    cmp1("core clock after reset", cpu_clk_en, 1'b1);
    cmp8("select after reset", {6'h0, clk_src_sel}, 8'h00);
    reg_read(ADDR_OSC_CTRL, v);
    cmp8("osc ctrl reset", v, {FREQ_RESET, 4'h0});
    reg_read(ADDR_CORE_STAT, v);
    cmp8("core stat reset", v, 8'h03);
    reg_read(4'hF, v);
    cmp8("unmapped read", v, 8'h00);
  endtask
  // one sleep and interrupt wake; dly sets how long the partner keeps quiet
  task automatic sleep_wake(input logic g, input logic [7:0] dly, input logic lf,
                            input logic pin, input logic rc);
    @(posedge clk);
    irq_glb_en <= g;
    t1_lf     <= lf;
    t1_pin    <= pin;
    adc_rc    <= rc;
    delay     <= dly;
    arm       <= 1'b1;
    sleep_req <= 1'b1;
    io_exp    = io_out_in;
    #1;
    cmp1("prefetch", prefetch_req, 1'b1);
    @(posedge clk);
    sleep_req <= 1'b0;
    io_out_in <= ~io_out_in;
    #1;
    cmp1("core clock stop", cpu_clk_en, 1'b0);
    cmp1("lf osc", lf_osc_en, 1'b1);
    cmp1("powerdown entry", powerdown_flag, 1'b0);
    cmp1("timeout entry", timeout_flag_n, 1'b1);
    cmp1("timer1 runs", timer1_run, lf | pin);
    cmp1("adc runs", adc_run, rc);
    @(posedge clk);
    #1;
    cmp8("pins held", {3'h0, io_out}, {3'h0, io_exp});
    n = 0;
    while (resume_pulse !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    cmp1("resume", resume_pulse, 1'b1);
    cmp1("sync delay", n >= dly + 3, 1'b1);
    cmp1("core clock back", cpu_clk_en, 1'b1);
    @(posedge clk);
    arm <= 1'b0;
    #1;
    cmp1("vector", vector_isr, g);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // hang guard: the tests need under two hundred cycles, this allows thirty thousand
  initial begin
    #3_000_000;
    fails++;
    end_sim();
  end
  initial begin
    rst = 1'b1;
    {sleep_req, irq_pending, irq_glb_en, arm, reg_wr, reg_rd} = 6'h00;
    {wdt_en, t1_lf, t1_pin, adc_rc} = 4'h0;
    reg_addr  = 4'h0;
    reg_wdata = 8'h00;
    delay     = 8'h00;
    io_out_in = 5'h15;
    io_oe_in  = 5'h0A;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    #1;
    check_reset_state();
    // clock switch table, poll the switching bit before judging the result
    foreach (rows[i]) begin
      reg_write(ADDR_OSC_CTRL, rows[i].wdata);
      n  = 0;
      rd = 8'h80;
      while (rd[7] !== 1'b0 && n < 40) begin
        reg_read(ADDR_OSC_STAT, rd);
        n++;
      end
      cmp8("select", {6'h0, clk_src_sel}, {6'h0, rows[i].src});
      cmp1("ready bit", rd[rows[i].src], 1'b1);
      cmp1("pll ready", rd[4], rows[i].pll);
      if (rows[i].slow) begin
        cmp1("hf settle", 2 * n + 4 >= HF_SETTLE_CYC, 1'b1);
      end
    end
    // interrupt already pending: sleep must act as a no-op
    @(posedge clk);
    irq_pending <= 1'b1;
    sleep_req   <= 1'b1;
    @(posedge clk);
    sleep_req   <= 1'b0;
    #1;
    cmp1("nop clock", cpu_clk_en, 1'b1);
    cmp1("nop powerdown", powerdown_flag, 1'b1);
    cmp1("nop timeout", timeout_flag_n, 1'b1);
    @(posedge clk);
    irq_pending <= 1'b0;
    sleep_wake(1'b1, 8'h00, 1'b1, 1'b0, 1'b1);
    sleep_wake(1'b0, 8'h07, 1'b0, 1'b1, 1'b0);
    // watchdog overflow in run: 16 counts of the 4-bit counter, then the request
    @(posedge clk);
    wdt_en <= 1'b1;
    repeat (20) @(posedge clk);
    wdt_en <= 1'b0;
    #1;
    cmp1("watchdog reset request", wd_req, 1'b1);
    cmp1("timeout on overflow", timeout_flag_n, 1'b0);
    // full reset arriving in mid-sleep, with timer1 and converter clocks stopped
    @(posedge clk);
    sleep_req <= 1'b1;
    t1_pin    <= 1'b0;
    @(posedge clk);
    sleep_req <= 1'b0;
    #1;
    cmp1("timer1 halts", timer1_run, 1'b0);
    cmp1("adc halts", adc_run, 1'b0);
    cmp1("timeout set on entry", timeout_flag_n, 1'b1);
    repeat (3) @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    #1;
    check_reset_state();
    end_sim();
  end
endmodule
